// [src/vectored_request_controller_pkg.sv]
// Behaviour
// - Each request is fast, vectored or non-vectored.
// - Fast class outranks both normal classes.
// - Fast-class requests OR into the fast output.
// - Readable word shows pending fast-class sources.
// - Sixteen slots, any source to any slot.
// - Lower slot index wins; slot zero highest.
// - Non-vectored requests have the lowest priority.
// - Vectored and non-vectored requests OR into normal output.
// - Vector register gives winning slot's address.
// - No vectored request: vector gives default address.
// - Readable word shows active normal-class requests.
package vectored_request_controller_pkg;

	// ------------------------------------------------------------------
	// Bus geometry and register map (byte addresses).
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8; // Byte address width of the register window.
	localparam int DATA_W = 32; // Bus data width.
	localparam logic [7:0] OFS_CLASS_FAST = 8'h00; // Per-source fast class select.
	localparam logic [7:0] OFS_ENABLE = 8'h04; // Per-source request enable.
	localparam logic [7:0] OFS_FAST_STATUS = 8'h08; // Pending fast-class sources.
	localparam logic [7:0] OFS_NORMAL_STATUS = 8'h0C; // Pending normal-class sources.
	localparam logic [7:0] OFS_RAW_STATUS = 8'h10; // Raw request lines.
	localparam logic [7:0] OFS_VECTOR = 8'h14; // Current service-routine address.
	localparam logic [7:0] OFS_DEFAULT = 8'h18; // Default routine address.
	localparam logic [7:0] OFS_EVT_STATUS = 8'h1C; // Sticky events, read clears.
	localparam logic [7:0] OFS_EVT_MASK = 8'h20; // Event interrupt mask.
	localparam logic [1:0] SEL_SLOT_CTRL = 2'h1; // Address bits 7:6 for slot control.
	localparam logic [1:0] SEL_SLOT_ADDR = 2'h2; // Address bits 7:6 for slot address.

	// ------------------------------------------------------------------
	// Field layouts.
	// ------------------------------------------------------------------
	localparam int NUM_SLOTS = 16; // Vectored slots.
	localparam int SLOT_IDX_W = 4; // Slot index width.
	localparam int SRC_FIELD_W = 5; // Source number field in slot control.
	localparam int SLOT_EN_BIT = 5; // Slot enable bit in slot control.
	localparam int EVT_W = 2; // Number of sticky events.
	localparam int EVT_FAST_BIT = 0; // Fast output went high.
	localparam int EVT_NORMAL_BIT = 1; // Normal output went high.

	// ------------------------------------------------------------------
	// Values after reset.
	// ------------------------------------------------------------------
	localparam logic [31:0] RST_CLASS_FAST = 32'h0000_0000; // All sources normal.
	localparam logic [31:0] RST_ENABLE = 32'h0000_0000; // All sources disabled.
	localparam logic [31:0] RST_ADDR = 32'h0000_0000; // Routine addresses.
	localparam logic [4:0] RST_SLOT_SRC = 5'h00; // Slot source number.
	localparam logic [1:0] RST_EVT = 2'h0; // Events and mask.

endpackage

// [src/slot_priority_picker.sv]
`timescale 1ns/10ps
// Picks the lowest-numbered active slot out of a set of slot hits.
module slot_priority_picker #(
	parameter int N = 16, // Number of slots.
	parameter int IW = 4 // Index width.
) (
	input wire logic [N-1:0] hits, // One bit per slot, high when it requests.
	output logic [IW-1:0] win_idx, // Index of the winning slot.
	output logic any_hit // High when any slot requests.
);

	// ------------------------------------------------------------------
	// Priority search.
	// ------------------------------------------------------------------
	// Scanning downward lets the lowest index overwrite the others last.
	always_comb
	begin
		win_idx = '0;
		any_hit = 1'b0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (hits[i])
			begin
				win_idx = IW'(i);
				any_hit = 1'b1;
			end
		end
	end

endmodule // slot_priority_picker

// [src/vectored_request_controller.sv]
`timescale 1ns/10ps
// Vectored interrupt controller with an Avalon-MM register slave.
module vectored_request_controller #(
	parameter int NUM_SRC = 32 // Number of peripheral request lines, 32 at most.
) (
	input wire logic sys_clk, // System clock, 125 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [NUM_SRC-1:0] periph_req, // Level requests, one per peripheral.
	output logic fast_interrupt_request, // Fast request to the core.
	output logic normal_interrupt_request, // Normal request to the core.
	output logic event_irq, // Level interrupt from unmasked sticky events.
	input wire logic [7:0] avs_address, // Avalon byte address.
	input wire logic avs_read, // Avalon read strobe.
	input wire logic avs_write, // Avalon write strobe.
	input wire logic [3:0] avs_byteenable, // Avalon byte enables.
	input wire logic [31:0] avs_writedata, // Avalon write data.
	output logic [31:0] avs_readdata, // Avalon read data.
	output logic avs_waitrequest // Avalon wait request.
);

	localparam int SRC_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1; // Source index width.

	// ------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------
	logic [NUM_SRC-1:0] class_fast; // High bit puts a source in the fast class.
	logic [NUM_SRC-1:0] next_class_fast; // Next class selection.
	logic [NUM_SRC-1:0] src_enable; // Per-source enable.
	logic [NUM_SRC-1:0] next_src_enable; // Next enable.
	logic [4:0] slot_src [vectored_request_controller_pkg::NUM_SLOTS]; // Bound source.
	logic [4:0] next_slot_src [vectored_request_controller_pkg::NUM_SLOTS]; // Next binding.
	logic [vectored_request_controller_pkg::NUM_SLOTS-1:0] slot_en; // Slot in use.
	logic [vectored_request_controller_pkg::NUM_SLOTS-1:0] next_slot_en; // Next slot use.
	logic [31:0] slot_addr [vectored_request_controller_pkg::NUM_SLOTS]; // Routine addresses.
	logic [31:0] next_slot_addr [vectored_request_controller_pkg::NUM_SLOTS]; // Next addresses.
	logic [31:0] default_addr; // Shared routine address for non-vectored sources.
	logic [31:0] next_default_addr; // Next default address.
	logic [1:0] evt_status; // Sticky events.
	logic [1:0] next_evt_status; // Next sticky events.
	logic [1:0] evt_mask; // Event mask, high enables.
	logic [1:0] next_evt_mask; // Next mask.
	logic [NUM_SRC-1:0] fast_active; // Enabled fast-class requests.
	logic [NUM_SRC-1:0] normal_active; // Enabled normal-class requests.
	logic [31:0] normal_wide; // Normal requests padded to a full word.
	logic [vectored_request_controller_pkg::NUM_SLOTS-1:0] slot_hits; // Requesting slots.
	logic [vectored_request_controller_pkg::SLOT_IDX_W-1:0] win_idx; // Winning slot.
	logic any_vectored; // Some slot requests.
	logic [31:0] vector_addr; // Registered current vector.
	logic [31:0] next_vector_addr; // Next vector.
	logic next_fast; // Next fast output.
	logic next_normal; // Next normal output.
	logic bus_ack; // High in the cycle an access completes.
	logic next_bus_ack; // Next completion flag.
	logic [31:0] next_readdata; // Read data to capture.
	logic req_any; // A read or write is presented.
	logic wr_take; // A write completes at this edge.
	logic rd_take; // A read completes at this edge.
	logic [31:0] wmask; // Write data bit mask from byte enables.
	logic [31:0] wmerge; // Write data masked by the byte enables.

	// ------------------------------------------------------------------
	// Classification of requests.
	// ------------------------------------------------------------------
	// A fast-class source never counts as normal, which gives fast the upper hand.
	always_comb
	begin
		fast_active = periph_req & src_enable & class_fast;
		normal_active = periph_req & src_enable & ~class_fast;
		normal_wide = 32'(normal_active);
	end

	// One hit per slot; sources that are both bound and fast stay fast only.
	genvar g;
	generate
		for (g = 0; g < vectored_request_controller_pkg::NUM_SLOTS; g++)
		begin : gen_slot_hit
			assign slot_hits[g] = slot_en[g] & normal_wide[slot_src[g]];
		end
	endgenerate

	// Lowest slot index wins the vector.
	slot_priority_picker #(
		.N(vectored_request_controller_pkg::NUM_SLOTS),
		.IW(vectored_request_controller_pkg::SLOT_IDX_W)
	) u_picker (
		.hits(slot_hits),
		.win_idx(win_idx),
		.any_hit(any_vectored)
	);

	// ------------------------------------------------------------------
	// Core outputs and vector.
	// ------------------------------------------------------------------
	// Outputs are registered so the core sees glitch-free lines, at one cycle of latency.
	always_comb
	begin
		next_fast = |fast_active;
		next_normal = |normal_active;
		if (any_vectored)
		begin
			next_vector_addr = slot_addr[win_idx];
		end
		else
		begin
			next_vector_addr = default_addr;
		end
	end

	// Register the core-facing state.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fast_interrupt_request <= 1'b0;
			normal_interrupt_request <= 1'b0;
			vector_addr <= vectored_request_controller_pkg::RST_ADDR;
		end
		else
		begin
			fast_interrupt_request <= next_fast;
			normal_interrupt_request <= next_normal;
			vector_addr <= next_vector_addr;
		end
	end

	// ------------------------------------------------------------------
	// Avalon-MM handshake.
	// ------------------------------------------------------------------
	// Every access waits exactly one cycle; the second edge completes it.
	always_comb
	begin
		req_any = avs_read | avs_write;
		next_bus_ack = req_any & ~bus_ack;
		avs_waitrequest = req_any & ~bus_ack;
		wr_take = avs_write & bus_ack;
		rd_take = avs_read & bus_ack;
		for (int b = 0; b < 4; b++)
		begin
			wmask[8*b +: 8] = {8{avs_byteenable[b]}};
		end
		wmerge = avs_writedata & wmask;
	end

	// Read data is captured in the wait cycle and stands at the completing edge.
	always_comb
	begin
		next_readdata = avs_readdata;
		if (avs_read & ~bus_ack)
		begin
			next_readdata = 32'h0000_0000; // Unmapped addresses read as zero.
			case (avs_address[7:6])
				vectored_request_controller_pkg::SEL_SLOT_CTRL:
				begin
					next_readdata = {26'h0, slot_en[avs_address[5:2]], slot_src[avs_address[5:2]]};
				end
				vectored_request_controller_pkg::SEL_SLOT_ADDR:
				begin
					next_readdata = slot_addr[avs_address[5:2]];
				end
				default:
				begin
					case (avs_address)
						vectored_request_controller_pkg::OFS_CLASS_FAST:
							next_readdata = 32'(class_fast);
						vectored_request_controller_pkg::OFS_ENABLE:
							next_readdata = 32'(src_enable);
						vectored_request_controller_pkg::OFS_FAST_STATUS:
							next_readdata = 32'(fast_active);
						vectored_request_controller_pkg::OFS_NORMAL_STATUS:
							next_readdata = normal_wide;
						vectored_request_controller_pkg::OFS_RAW_STATUS:
							next_readdata = 32'(periph_req);
						vectored_request_controller_pkg::OFS_VECTOR:
							next_readdata = vector_addr;
						vectored_request_controller_pkg::OFS_DEFAULT:
							next_readdata = default_addr;
						vectored_request_controller_pkg::OFS_EVT_STATUS:
							next_readdata = {30'h0, evt_status};
						vectored_request_controller_pkg::OFS_EVT_MASK:
							next_readdata = {30'h0, evt_mask};
						default:
							next_readdata = 32'h0000_0000;
					endcase
				end
			endcase
		end
	end

	// Register the handshake state.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			bus_ack <= next_bus_ack;
			avs_readdata <= next_readdata;
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers.
	// ------------------------------------------------------------------
	// Software may rewrite class and slot settings at any time; the new
	// classification takes effect on the outputs one cycle after the write.
	always_comb
	begin
		next_class_fast = class_fast;
		next_src_enable = src_enable;
		next_slot_src = slot_src;
		next_slot_en = slot_en;
		next_slot_addr = slot_addr;
		next_default_addr = default_addr;
		next_evt_mask = evt_mask;
		if (wr_take)
		begin
			case (avs_address[7:6])
				vectored_request_controller_pkg::SEL_SLOT_CTRL:
				begin
					if (avs_byteenable[0])
					begin
						next_slot_src[avs_address[5:2]] = avs_writedata[4:0];
						next_slot_en[avs_address[5:2]] =
							avs_writedata[vectored_request_controller_pkg::SLOT_EN_BIT];
					end
				end
				vectored_request_controller_pkg::SEL_SLOT_ADDR:
				begin
					next_slot_addr[avs_address[5:2]] =
						(slot_addr[avs_address[5:2]] & ~wmask) | wmerge;
				end
				default:
				begin
					case (avs_address)
						vectored_request_controller_pkg::OFS_CLASS_FAST:
							next_class_fast = NUM_SRC'((32'(class_fast) & ~wmask) | wmerge);
						vectored_request_controller_pkg::OFS_ENABLE:
							next_src_enable = NUM_SRC'((32'(src_enable) & ~wmask) | wmerge);
						vectored_request_controller_pkg::OFS_DEFAULT:
							next_default_addr = (default_addr & ~wmask) | wmerge;
						vectored_request_controller_pkg::OFS_EVT_MASK:
						begin
							if (avs_byteenable[0])
							begin
								next_evt_mask = avs_writedata[1:0];
							end
						end
						default:
						begin
							next_evt_mask = evt_mask; // Read-only or unmapped: ignored.
						end
					endcase
				end
			endcase
		end
	end

	// Register the configuration.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			class_fast <= NUM_SRC'(vectored_request_controller_pkg::RST_CLASS_FAST);
			src_enable <= NUM_SRC'(vectored_request_controller_pkg::RST_ENABLE);
			slot_en <= '0;
			default_addr <= vectored_request_controller_pkg::RST_ADDR;
			evt_mask <= vectored_request_controller_pkg::RST_EVT;
			for (int s = 0; s < vectored_request_controller_pkg::NUM_SLOTS; s++)
			begin
				slot_src[s] <= vectored_request_controller_pkg::RST_SLOT_SRC;
				slot_addr[s] <= vectored_request_controller_pkg::RST_ADDR;
			end
		end
		else
		begin
			class_fast <= next_class_fast;
			src_enable <= next_src_enable;
			slot_src <= next_slot_src;
			slot_en <= next_slot_en;
			slot_addr <= next_slot_addr;
			default_addr <= next_default_addr;
			evt_mask <= next_evt_mask;
		end
	end

	// ------------------------------------------------------------------
	// Sticky events and event interrupt.
	// ------------------------------------------------------------------
	// A read of the status word clears the bits it reported, but a rising output in the same
	// cycle sets its bit again so the event is never lost.
	always_comb
	begin
		next_evt_status = evt_status;
		if (rd_take && avs_address == vectored_request_controller_pkg::OFS_EVT_STATUS)
		begin
			// Only the bits that the read reported are cleared. An event set in the
			// wait cycle missed the captured word and must survive for the next read.
			next_evt_status = evt_status & ~avs_readdata[1:0];
		end
		if (next_fast && !fast_interrupt_request)
		begin
			next_evt_status[vectored_request_controller_pkg::EVT_FAST_BIT] = 1'b1;
		end
		if (next_normal && !normal_interrupt_request)
		begin
			next_evt_status[vectored_request_controller_pkg::EVT_NORMAL_BIT] = 1'b1;
		end
		event_irq = |(evt_status & evt_mask);
	end

	// Register the events.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			evt_status <= vectored_request_controller_pkg::RST_EVT;
		end
		else
		begin
			evt_status <= next_evt_status;
		end
	end

endmodule // vectored_request_controller

// [tb/vrc_checker_properties.sv]
`timescale 1ns/10ps
// ----
// Port checker for the request controller.
// ----
module vrc_checker #(
	parameter int NUM_SRC = 32 // Number of request lines.
) (
	input wire logic sys_clk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic [NUM_SRC-1:0] periph_req, // Request lines.
	input wire logic fast_interrupt_request, // Fast output.
	input wire logic normal_interrupt_request, // Normal output.
	input wire logic event_irq, // Event interrupt.
	input wire logic [7:0] avs_address, // Bus address.
	input wire logic avs_read, // Read strobe.
	input wire logic avs_write, // Write strobe.
	input wire logic [3:0] avs_byteenable, // Byte enables.
	input wire logic [31:0] avs_writedata, // Write data.
	input wire logic [31:0] avs_readdata, // Read data.
	input wire logic avs_waitrequest // Wait request.
);
	logic rd_done; // A read completes at this edge.
	logic wr_done; // A write completes at this edge.
	assign rd_done = avs_read && !avs_waitrequest;
	assign wr_done = avs_write && !avs_waitrequest;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Each access waits exactly one cycle, and an idle bus never waits.
	wait_first_a: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
		else $error("No wait cycle at start of access.");
	wait_one_a: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("Wait lasted more than one cycle.");
	idle_nowait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("Wait request while idle.");
	// Outputs move only when requests or settings move; levels are held.
	fast_hold_a: assert property ($stable(periph_req) && !$past(wr_done) |=> $stable(fast_interrupt_request))
		else $error("Fast output changed with steady inputs.");
	normal_hold_a: assert property ($stable(periph_req) && !$past(wr_done) |=> $stable(normal_interrupt_request))
		else $error("Normal output changed with steady inputs.");
	fast_quiet_a: assert property (!(|$past(periph_req)) |-> !fast_interrupt_request)
		else $error("Fast output without any request.");
	// A nonzero status word must agree with the matching output.
	fast_status_a: assert property (rd_done && avs_address == vectored_request_controller_pkg::OFS_FAST_STATUS
		&& avs_readdata != 32'h0 |-> fast_interrupt_request || $past(fast_interrupt_request))
		else $error("Fast status set with fast output low.");
	normal_status_a: assert property (rd_done && avs_address == vectored_request_controller_pkg::OFS_NORMAL_STATUS
		&& avs_readdata != 32'h0 |-> normal_interrupt_request || $past(normal_interrupt_request))
		else $error("Normal status set with normal output low.");
	evt_reset_a: assert property (!$past(rst_n) |-> !event_irq)
		else $error("Event interrupt high after reset.");
	fast_seen_c: cover property ($rose(fast_interrupt_request));
	normal_seen_c: cover property ($rose(normal_interrupt_request));
	evt_seen_c: cover property ($rose(event_irq));
endmodule // vrc_checker

bind vectored_request_controller vrc_checker #(.NUM_SRC(NUM_SRC)) chk_i (.sys_clk(sys_clk),
	.rst_n(rst_n), .periph_req(periph_req), .fast_interrupt_request(fast_interrupt_request),
	.normal_interrupt_request(normal_interrupt_request), .event_irq(event_irq),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// [tb/core_model.sv]
`timescale 1ns/10ps
// ----
// Core side: counts each new fast and normal request entry.
// ----
module core_model (
	input wire logic sys_clk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic fast_interrupt_request, // Fast request level.
	input wire logic normal_interrupt_request, // Normal request level.
	output int fast_rises, // Fast entries seen.
	output int normal_rises // Normal entries seen.
);
	logic fast_q; // Previous fast level.
	logic normal_q; // Previous normal level.
	// The core reacts to levels, so only a low-to-high step is a new entry.
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fast_q <= 1'b0;
			normal_q <= 1'b0;
			fast_rises <= 0;
			normal_rises <= 0;
		end
		else
		begin
			fast_q <= fast_interrupt_request;
			normal_q <= normal_interrupt_request;
			fast_rises <= fast_rises + int'(fast_interrupt_request && !fast_q);
			normal_rises <= normal_rises + int'(normal_interrupt_request && !normal_q);
		end
	end
endmodule // core_model

// [tb/test_vectored_request_controller.sv]
`timescale 1ns/10ps
// ----
// Self-checking bench for the request controller.
// ----
module test_vectored_request_controller;
	logic sys_clk = 1'b0; // Clock, 8 ns period.
	logic rst_n = 1'b0; // Reset, active low.
	logic [31:0] periph_req = 32'h0; // One line per peripheral.
	logic fast_interrupt_request; // Fast output.
	logic normal_interrupt_request; // Normal output.
	logic event_irq; // Event interrupt.
	logic [7:0] avs_address = 8'h00; // Bus address.
	logic avs_read = 1'b0; // Read strobe.
	logic avs_write = 1'b0; // Write strobe.
	logic [31:0] avs_writedata = 32'h0; // Write data.
	logic [3:0] avs_byteenable = 4'hF; // Byte enables.
	logic [31:0] avs_readdata; // Read data.
	logic avs_waitrequest; // Wait request.
	logic [31:0] rd; // Last word read.
	int fails = 0; // Mismatches.
	int total_checks = 0; // Comparisons.
	int cycles = 0; // Cycles run.
	int fast_rises; // Fast entries at the core.
	int normal_rises; // Normal entries at the core.
	always #4 sys_clk = ~sys_clk;
	vectored_request_controller uut (.sys_clk(sys_clk), .rst_n(rst_n), .periph_req(periph_req),
		.fast_interrupt_request(fast_interrupt_request),
		.normal_interrupt_request(normal_interrupt_request), .event_irq(event_irq),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	core_model core_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.fast_interrupt_request(fast_interrupt_request),
		.normal_interrupt_request(normal_interrupt_request),
		.fast_rises(fast_rises), .normal_rises(normal_rises));
	// ----
	// Tasks.
	// ----
	// Compares one word and reports a mismatch at once.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask
	// One bus access; called just after an edge, holds until wait drops.
	// A slave that never answers is caught by the bench timeout.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= d;
		do
		begin
			@(posedge sys_clk);
		end
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Reads a register and compares it.
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	// Outputs follow requests one edge later; two edges leave margin.
	task automatic settle;
		repeat (2) @(posedge sys_clk);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic summarize;
		$display("Checks: %0d, mismatches: %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// A hang ends the run as a failure.
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			summarize;
		end
	end
	// ----
	// Main sequence.
	// ----
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		// Writable settings start cleared; an unmapped word reads zero.
		rdchk(vectored_request_controller_pkg::OFS_CLASS_FAST, 32'h0);
		rdchk(vectored_request_controller_pkg::OFS_ENABLE, 32'h0);
		rdchk(vectored_request_controller_pkg::OFS_DEFAULT, 32'h0);
		bus(1'b1, 8'h30, 32'hFFFF_FFFF);
		rdchk(8'h30, 32'h0);
		// Only the two low bytes of the default address are written.
		avs_byteenable <= 4'h3;
		bus(1'b1, vectored_request_controller_pkg::OFS_DEFAULT, 32'hFFFF_1234);
		avs_byteenable <= 4'hF;
		rdchk(vectored_request_controller_pkg::OFS_DEFAULT, 32'h0000_1234);
		// Sources 2 and 5 in the fast class; event masked at first.
		bus(1'b1, vectored_request_controller_pkg::OFS_CLASS_FAST, 32'h0000_0024);
		bus(1'b1, vectored_request_controller_pkg::OFS_ENABLE, 32'h0000_0024);
		periph_req <= 32'h0000_0004;
		settle;
		check(32'(fast_interrupt_request), 32'h1);
		check(32'(normal_interrupt_request), 32'h0);
		check(32'(event_irq), 32'h0);
		bus(1'b1, vectored_request_controller_pkg::OFS_EVT_MASK, 32'h0000_0001);
		check(32'(event_irq), 32'h1);
		rdchk(vectored_request_controller_pkg::OFS_FAST_STATUS, 32'h0000_0004);
		rdchk(vectored_request_controller_pkg::OFS_EVT_STATUS, 32'h0000_0001);
		check(32'(event_irq), 32'h0);
		periph_req <= 32'h0000_0020;
		settle;
		check(32'(fast_interrupt_request), 32'h1);
		rdchk(vectored_request_controller_pkg::OFS_FAST_STATUS, 32'h0000_0020);
		periph_req <= 32'h0;
		settle;
		check(32'(fast_interrupt_request), 32'h0);
		// Slot n serves source 8+n at address 1000h+16n.
		for (int i = 0; i < 16; i++)
		begin
			bus(1'b1, {vectored_request_controller_pkg::SEL_SLOT_CTRL, i[3:0], 2'b00}, 32'(32 + 8 + i));
			bus(1'b1, {vectored_request_controller_pkg::SEL_SLOT_ADDR, i[3:0], 2'b00}, 32'(4096 + 16 * i));
		end
		bus(1'b1, vectored_request_controller_pkg::OFS_DEFAULT, 32'h0000_D000);
		bus(1'b1, vectored_request_controller_pkg::OFS_CLASS_FAST, 32'h0);
		bus(1'b1, vectored_request_controller_pkg::OFS_ENABLE, 32'h40FF_FF00);
		// Drop the winners one by one: the next slot must take over.
		for (int k = 0; k < 16; k++)
		begin
			periph_req <= 32'h00FF_FF00 & (32'h00FF_FF00 << k);
			settle;
			rdchk(vectored_request_controller_pkg::OFS_VECTOR, 32'(4096 + 16 * k));
			check(32'(normal_interrupt_request), 32'h1);
		end
		// Non-vectored source alone, then beside slot 12.
		periph_req <= 32'h4000_0000;
		settle;
		rdchk(vectored_request_controller_pkg::OFS_VECTOR, 32'h0000_D000);
		rdchk(vectored_request_controller_pkg::OFS_NORMAL_STATUS, 32'h4000_0000);
		periph_req <= 32'h4010_0000;
		settle;
		rdchk(vectored_request_controller_pkg::OFS_VECTOR, 32'h0000_10C0);
		// Source 20 moved to the fast class in mid-run leaves its slot.
		bus(1'b1, vectored_request_controller_pkg::OFS_CLASS_FAST, 32'h0010_0000);
		settle;
		rdchk(vectored_request_controller_pkg::OFS_VECTOR, 32'h0000_D000);
		check(32'(fast_interrupt_request), 32'h1);
		rdchk(vectored_request_controller_pkg::OFS_NORMAL_STATUS, 32'h4000_0000);
		rdchk(vectored_request_controller_pkg::OFS_EVT_STATUS, 32'h0000_0003);
		periph_req <= 32'h0;
		settle;
		check(32'(normal_interrupt_request), 32'h0);
		check(32'(fast_rises), 32'h2);
		check(32'(normal_rises), 32'h1);
		summarize;
	end
endmodule // test_vectored_request_controller
